// file: gpb_pkg.sv
package gpb_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_P0_DATA  = 8'h80;
   localparam logic [7:0] IDX_P1_DATA  = 8'h90;
   localparam logic [7:0] IDX_P1_DIR   = 8'h91;
   localparam logic [7:0] IDX_P1_PULL  = 8'h92;
   localparam logic [7:0] IDX_DRIVE    = 8'h97;
   localparam logic [7:0] IDX_P0_DIR   = 8'h9A;
   localparam logic [7:0] IDX_P0_PULL  = 8'h9B;
   localparam logic [7:0] IDX_P2_DATA  = 8'hA0;
   localparam logic [7:0] IDX_P2_DIR   = 8'hA1;
   localparam logic [7:0] IDX_P2_PULL  = 8'hA2;
   localparam logic [7:0] IDX_P5_DATA  = 8'hD8;
   localparam logic [7:0] IDX_P5_DIR   = 8'hD9;
   localparam logic [7:0] IDX_P5_PULL  = 8'hDA;

   // Drive field positions (low bit of each 2-bit field).
   localparam int DRV_P2_UPPER_LSB = 6;
   localparam int DRV_P2_LOWER_LSB = 4;
   localparam int DRV_P0_UPPER_LSB = 2;
   localparam int DRV_P0_LOWER_LSB = 0;

   // Reset values and implemented-bit mask of port 5.
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [7:0] P5_MASK      = 8'h03;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef enum logic [3:0] {
      SEL_P0_DATA = 4'h0,
      SEL_P0_DIR  = 4'h1,
      SEL_P0_PULL = 4'h2,
      SEL_P1_DATA = 4'h3,
      SEL_P1_DIR  = 4'h4,
      SEL_P1_PULL = 4'h5,
      SEL_P2_DATA = 4'h6,
      SEL_P2_DIR  = 4'h7,
      SEL_P2_PULL = 4'h8,
      SEL_P5_DATA = 4'h9,
      SEL_P5_DIR  = 4'hA,
      SEL_P5_PULL = 4'hB,
      SEL_DRIVE   = 4'hC,
      SEL_NONE    = 4'hF
   } gpb_sel_e;

endpackage

// file: gpb_regfile.sv
`timescale 1ns/1ns
// Thirteen byte-wide control registers; read data leave through a flop.
module gpb_regfile
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // Write port
   input  wire logic        wr_en_i,
   input  wire logic [3:0]  wr_sel_i,
   input  wire logic [7:0]  wr_data_i,
   // Read port
   input  wire logic [3:0]  rd_sel_i,
   input  wire logic [25:0] pin_level_i,
   output logic      [7:0]  rd_data_o,
   // Stored contents, flat: index times eight
   output logic      [103:0] regs_o
);

   logic [7:0] mem_r   [0:12];
   logic [7:0] mem_nxt [0:12];
   logic [7:0] rd_r;
   logic [7:0] rd_nxt;

   always_comb
   begin
      for (int i = 0; i < 13; i++)
      begin
         mem_nxt[i] = mem_r[i];
      end
      if (wr_en_i && wr_sel_i < 4'hD)
      begin
         mem_nxt[wr_sel_i] = wr_data_i;
      end
      // Port 5 keeps only its two implemented bits.
      mem_nxt[gpb_pkg::SEL_P5_DATA] = mem_nxt[gpb_pkg::SEL_P5_DATA]
                                      & gpb_pkg::P5_MASK;
      mem_nxt[gpb_pkg::SEL_P5_DIR]  = mem_nxt[gpb_pkg::SEL_P5_DIR]
                                      & gpb_pkg::P5_MASK;
      mem_nxt[gpb_pkg::SEL_P5_PULL] = mem_nxt[gpb_pkg::SEL_P5_PULL]
                                      & gpb_pkg::P5_MASK;
      unique case (rd_sel_i)
         gpb_pkg::SEL_P0_DATA: rd_nxt = pin_level_i[7:0];
         gpb_pkg::SEL_P1_DATA: rd_nxt = pin_level_i[15:8];
         gpb_pkg::SEL_P2_DATA: rd_nxt = pin_level_i[23:16];
         gpb_pkg::SEL_P5_DATA: rd_nxt = {6'h00, pin_level_i[25:24]};
         default:
         begin
            rd_nxt = (rd_sel_i < 4'hD) ? mem_r[rd_sel_i] : 8'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 13; i++)
         begin
            mem_r[i] <= gpb_pkg::RST_BYTE;
         end
         rd_r <= gpb_pkg::RST_BYTE;
      end
      else
      begin
         for (int i = 0; i < 13; i++)
         begin
            mem_r[i] <= mem_nxt[i];
         end
         rd_r <= rd_nxt;
      end
   end

   assign rd_data_o = rd_r;

   always_comb
   begin
      for (int i = 0; i < 13; i++)
      begin
         regs_o[i*8 +: 8] = mem_r[i];
      end
   end

endmodule

// file: gpb_top.sv
`timescale 1ns/1ns
// Operation
// - Up to 26 two-way pins, direction set per pin by software.
// - Direction 1 drives the pin push-pull; 0 makes it an input.
// - All direction bits clear at reset, so every pin is input.
// - Pull-up bit acts only while the pin is an input.
// - Input pull-up off when bit is 0, on when 1; reset 0.
// - Data register reads give the real pin level in either mode.
// - Drive register bits 7:6 and 5:4 set port 2 nibbles.
// - Drive register bits 3:2 and 1:0 set port 0 nibbles.
// - Drive field 00 strongest, 11 weakest; reset 00.
// - Port 5 implements only bits 1 and 0.
module gpb_top
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pins: 0-7 port 0, 8-15 port 1, 16-23 port 2, 24-25 port 5
   input  wire logic [25:0] pin_i,
   output logic      [25:0] pin_o,
   output logic      [25:0] pin_oe_o,
   output logic      [25:0] pin_pullup_o,
   // High-side drive level per nibble
   output logic      [1:0]  port_zero_lower_drive_o,
   output logic      [1:0]  port_zero_upper_drive_o,
   output logic      [1:0]  port_two_lower_drive_o,
   output logic      [1:0]  port_two_upper_drive_o
);

   function automatic gpb_pkg::gpb_sel_e decode(input logic [31:0] a);
      logic [7:0] idx;
      gpb_pkg::gpb_sel_e s;
      idx = a[9:2];
      s = gpb_pkg::SEL_NONE;
      if (a[31:10] == 22'h000000 && a[1:0] == 2'h0)
      begin
         unique case (idx)
            gpb_pkg::IDX_P0_DATA: s = gpb_pkg::SEL_P0_DATA;
            gpb_pkg::IDX_P0_DIR:  s = gpb_pkg::SEL_P0_DIR;
            gpb_pkg::IDX_P0_PULL: s = gpb_pkg::SEL_P0_PULL;
            gpb_pkg::IDX_P1_DATA: s = gpb_pkg::SEL_P1_DATA;
            gpb_pkg::IDX_P1_DIR:  s = gpb_pkg::SEL_P1_DIR;
            gpb_pkg::IDX_P1_PULL: s = gpb_pkg::SEL_P1_PULL;
            gpb_pkg::IDX_P2_DATA: s = gpb_pkg::SEL_P2_DATA;
            gpb_pkg::IDX_P2_DIR:  s = gpb_pkg::SEL_P2_DIR;
            gpb_pkg::IDX_P2_PULL: s = gpb_pkg::SEL_P2_PULL;
            gpb_pkg::IDX_P5_DATA: s = gpb_pkg::SEL_P5_DATA;
            gpb_pkg::IDX_P5_DIR:  s = gpb_pkg::SEL_P5_DIR;
            gpb_pkg::IDX_P5_PULL: s = gpb_pkg::SEL_P5_PULL;
            gpb_pkg::IDX_DRIVE:   s = gpb_pkg::SEL_DRIVE;
            default:              s = gpb_pkg::SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // Write channel state.
   logic        aw_held_r, aw_held_nxt;
   logic        w_held_r, w_held_nxt;
   logic [31:0] aw_addr_r, aw_addr_nxt;
   logic [7:0]  w_byte_r, w_byte_nxt;
   logic        w_lane_r, w_lane_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        awrdy_r, wrdy_r, ardy_r;
   // Read channel state.
   logic        rpend_r, rpend_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [1:0]  rresp_r, rresp_nxt;
   logic [3:0]  rsel_r, rsel_nxt;
   // Pin state.
   logic [25:0] pin_out_r, pin_out_nxt;
   logic [25:0] pin_oe_r, pin_oe_nxt;
   logic [25:0] pull_r, pull_nxt;
   logic [7:0]  drive_r, drive_nxt;

   logic             wr_en;
   gpb_pkg::gpb_sel_e wr_sel;
   logic [7:0]       rd_byte;
   logic [103:0]     regs;

   gpb_regfile u_regs
   (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .wr_en_i     (wr_en),
      .wr_sel_i    (wr_sel),
      .wr_data_i   (w_byte_r),
      .rd_sel_i    (rsel_r),
      .pin_level_i (pin_i),
      .rd_data_o   (rd_byte),
      .regs_o      (regs)
   );

   // Write path: address and data may arrive in either order.
   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      aw_addr_nxt = aw_addr_r;
      w_byte_nxt  = w_byte_r;
      w_lane_nxt  = w_lane_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      wr_sel      = decode(aw_addr_r);
      wr_en       = 1'b0;
      // Take a request only at its handshake edge, or it is taken twice.
      if (s_axi_awvalid && awrdy_r && !aw_held_r && !bvalid_r)
      begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wrdy_r && !w_held_r && !bvalid_r)
      begin
         w_held_nxt = 1'b1;
         w_byte_nxt = s_axi_wdata[7:0];
         w_lane_nxt = s_axi_wstrb[0];
      end
      if (aw_held_r && w_held_r)
      begin
         // A cleared lane-0 strobe leaves the register untouched.
         wr_en       = w_lane_r && wr_sel != gpb_pkg::SEL_NONE;
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = (wr_sel == gpb_pkg::SEL_NONE) ?
                       gpb_pkg::RESP_SLVERR : gpb_pkg::RESP_OKAY;
      end
      if (bvalid_r && s_axi_bready)
      begin
         bvalid_nxt = 1'b0;
      end
   end

   // Read path: one cycle to register the byte, then the answer.
   always_comb
   begin
      rpend_nxt  = 1'b0;
      rvalid_nxt = rvalid_r;
      rresp_nxt  = rresp_r;
      rsel_nxt   = rsel_r;
      if (s_axi_arvalid && ardy_r && !rpend_r && !rvalid_r)
      begin
         rsel_nxt  = decode(s_axi_araddr);
         rpend_nxt = 1'b1;
      end
      if (rpend_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = (rsel_r == gpb_pkg::SEL_NONE) ?
                      gpb_pkg::RESP_SLVERR : gpb_pkg::RESP_OKAY;
      end
      if (rvalid_r && s_axi_rready)
      begin
         rvalid_nxt = 1'b0;
      end
   end

   // Pin drive, taken from the register contents.
   always_comb
   begin
      logic [7:0] dir5;
      logic [7:0] dat5;
      logic [7:0] pul5;
      dir5 = regs[gpb_pkg::SEL_P5_DIR*8 +: 8];
      dat5 = regs[gpb_pkg::SEL_P5_DATA*8 +: 8];
      pul5 = regs[gpb_pkg::SEL_P5_PULL*8 +: 8];
      pin_oe_nxt = {dir5[1:0],
                    regs[gpb_pkg::SEL_P2_DIR*8 +: 8],
                    regs[gpb_pkg::SEL_P1_DIR*8 +: 8],
                    regs[gpb_pkg::SEL_P0_DIR*8 +: 8]};
      pin_out_nxt = {dat5[1:0],
                     regs[gpb_pkg::SEL_P2_DATA*8 +: 8],
                     regs[gpb_pkg::SEL_P1_DATA*8 +: 8],
                     regs[gpb_pkg::SEL_P0_DATA*8 +: 8]};
      pull_nxt = {pul5[1:0],
                  regs[gpb_pkg::SEL_P2_PULL*8 +: 8],
                  regs[gpb_pkg::SEL_P1_PULL*8 +: 8],
                  regs[gpb_pkg::SEL_P0_PULL*8 +: 8]} & ~pin_oe_nxt;
      drive_nxt = regs[gpb_pkg::SEL_DRIVE*8 +: 8];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 32'h00000000;
         w_byte_r  <= gpb_pkg::RST_BYTE;
         w_lane_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= gpb_pkg::RESP_OKAY;
         rpend_r   <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= gpb_pkg::RESP_OKAY;
         rsel_r    <= gpb_pkg::SEL_NONE;
         pin_out_r <= 26'h0000000;
         pin_oe_r  <= 26'h0000000;
         pull_r    <= 26'h0000000;
         drive_r   <= gpb_pkg::RST_BYTE;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_byte_r  <= w_byte_nxt;
         w_lane_r  <= w_lane_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rpend_r   <= rpend_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rsel_r    <= rsel_nxt;
         pin_out_r <= pin_out_nxt;
         pin_oe_r  <= pin_oe_nxt;
         pull_r    <= pull_nxt;
         drive_r   <= drive_nxt;
      end
   end

   // Ready flags are registered so the outputs come from flops.

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         awrdy_r <= 1'b0;
         wrdy_r  <= 1'b0;
         ardy_r  <= 1'b0;
      end
      else
      begin
         awrdy_r <= !aw_held_nxt && !bvalid_nxt && !awrdy_r;
         wrdy_r  <= !w_held_nxt && !bvalid_nxt && !wrdy_r;
         ardy_r  <= !rpend_nxt && !rvalid_nxt && !ardy_r;
      end
   end

   assign s_axi_awready = awrdy_r;
   assign s_axi_wready  = wrdy_r;
   assign s_axi_arready = ardy_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = {24'h000000, rd_byte};
   assign pin_o         = pin_out_r;
   assign pin_oe_o      = pin_oe_r;
   assign pin_pullup_o  = pull_r;
   assign port_two_upper_drive_o  =
      drive_r[gpb_pkg::DRV_P2_UPPER_LSB +: 2];
   assign port_two_lower_drive_o  =
      drive_r[gpb_pkg::DRV_P2_LOWER_LSB +: 2];
   assign port_zero_upper_drive_o =
      drive_r[gpb_pkg::DRV_P0_UPPER_LSB +: 2];
   assign port_zero_lower_drive_o =
      drive_r[gpb_pkg::DRV_P0_LOWER_LSB +: 2];

endmodule

// file: gpb_properties.sv
`timescale 1ns/1ns
module gpb_chk
(
   // Clock and reset
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   // Bus answers
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Pins and drive fields
   input wire logic [25:0] pin_o,
   input wire logic [25:0] pin_oe_o,
   input wire logic [25:0] pin_pullup_o,
   input wire logic [1:0]  port_zero_lower_drive_o,
   input wire logic [1:0]  port_zero_upper_drive_o,
   input wire logic [1:0]  port_two_lower_drive_o,
   input wire logic [1:0]  port_two_upper_drive_o
);
   logic [7:0]  drv;
   logic [85:0] pins;
   assign drv = {port_two_upper_drive_o, port_two_lower_drive_o,
                 port_zero_upper_drive_o, port_zero_lower_drive_o};
   assign pins = {drv, pin_o, pin_oe_o, pin_pullup_o};
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   property p_dir_reset; $past(rst_i) |-> pin_oe_o == 26'h0; endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("direction set after reset");
   property p_drv_reset; $past(rst_i) |-> drv == 8'h00; endproperty
   a_drv_reset: assert property (p_drv_reset)
      else $error("drive level not zero after reset");
   property p_pull_reset; $past(rst_i) |-> pin_pullup_o == 26'h0; endproperty
   a_pull_reset: assert property (p_pull_reset)
      else $error("pull-up on after reset");
   property p_pull_input; (pin_pullup_o & pin_oe_o) == 26'h0; endproperty
   a_pull_input: assert property (p_pull_input)
      else $error("pull-up on an output pin");
   // A read must never disturb the pins, so any move needs a write answer.
   property p_after_write;
      !$stable(pins) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
   endproperty
   a_after_write: assert property (p_after_write)
      else $error("pin outputs moved without a write");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once)
      else $error("write answer repeated");
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once)
      else $error("read answer repeated");
   property p_rd_answer;
      $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready, 2);
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer at wrong time");
   property p_rd_width;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rd_width: assert property (p_rd_width)
      else $error("read data above the byte");
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_pullup: cover property (pin_pullup_o != 26'h0);
   c_output: cover property (pin_oe_o == 26'h3FFFFFF);
endmodule
bind gpb_top gpb_chk u_chk (.sys_clk_i, .rst_i, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .pin_o, .pin_oe_o, .pin_pullup_o,
   .port_zero_lower_drive_o, .port_zero_upper_drive_o,
   .port_two_lower_drive_o, .port_two_upper_drive_o);

// file: gpb_pins.sv
`timescale 1ns/1ns
module gpb_pins
(
   // Clock
   input  wire logic        sys_clk_i,
   // Device side
   input  wire logic [25:0] drv_i,
   input  wire logic [25:0] oe_i,
   input  wire logic [25:0] pullup_i,
   // Board side
   input  wire logic [25:0] ext_i,
   input  wire logic [25:0] ext_en_i,
   output logic      [25:0] level_o
);
   logic [25:0] last_r = 26'h0000000;
   // wire level.
   // A floating pin flips each cycle so a held value is never mistaken.
   always_comb
   begin
      level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
              | (~oe_i & ~ext_en_i & (pullup_i | ~last_r));
   end
   always_ff @(posedge sys_clk_i)
   begin
      last_r <= level_o;
   end
endmodule

// file: tb.sv
`timescale 1ns/1ns
module tb;
   logic        sys_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [25:0] pin_i, pin_o, pin_oe_o, pin_pullup_o;
   logic [1:0]  port_zero_lower_drive_o, port_zero_upper_drive_o;
   logic [1:0]  port_two_lower_drive_o, port_two_upper_drive_o;
   logic [25:0] dir, dat, pu, ext;
   logic [7:0]  drv, v;
   logic [33:0] exp_q [$];
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [7:0]  cfg_idx [9] = '{gpb_pkg::IDX_P0_DIR, gpb_pkg::IDX_P0_PULL,
      gpb_pkg::IDX_P1_DIR, gpb_pkg::IDX_P1_PULL, gpb_pkg::IDX_P2_DIR,
      gpb_pkg::IDX_P2_PULL, gpb_pkg::IDX_P5_DIR, gpb_pkg::IDX_P5_PULL,
      gpb_pkg::IDX_DRIVE};
   assign drv = {port_two_upper_drive_o, port_two_lower_drive_o,
                 port_zero_upper_drive_o, port_zero_lower_drive_o};
   gpb_top dut (.sys_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o,
      .pin_oe_o, .pin_pullup_o, .port_zero_lower_drive_o,
      .port_zero_upper_drive_o, .port_two_lower_drive_o,
      .port_two_upper_drive_o);
   // Board drivers stay off wherever a pull-up is asked for.
   gpb_pins pins (.sys_clk_i, .drv_i(pin_o), .oe_i(pin_oe_o),
      .pullup_i(pin_pullup_o), .ext_i(ext), .ext_en_i(~pu), .level_o(pin_i));
   always #2 sys_clk_i = ~sys_clk_i;
   task automatic check(input logic [33:0] got, input logic [33:0] want);
      check_count++;
      if (got !== want)
      begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         fails++;
         finish_test();
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, exp_q.pop_front());
         if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   task automatic wr(input logic [7:0] i, input logic [7:0] d,
                     input logic [1:0] rsp);
      exp_q.push_back({rsp, 32'h0});
      s_axi_awaddr <= {22'h0, i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge sys_clk_i);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] d,
                     input logic [1:0] rsp);
      exp_q.push_back({rsp, 24'h0, d});
      s_axi_araddr <= {22'h0, i, 2'h0};
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge sys_clk_i);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
   endtask
   // Port 5 gets ones in its reserved bits; they must not stick.
   task automatic wports(input logic [7:0] a, b, c, e, input logic [25:0] x);
      wr(a, x[7:0], gpb_pkg::RESP_OKAY);
      wr(b, x[15:8], gpb_pkg::RESP_OKAY);
      wr(c, x[23:16], gpb_pkg::RESP_OKAY);
      wr(e, {6'h3F, x[25:24]}, gpb_pkg::RESP_OKAY);
   endtask
   task automatic rports(input logic [7:0] a, b, c, e, input logic [25:0] x);
      rd(a, x[7:0], gpb_pkg::RESP_OKAY);
      rd(b, x[15:8], gpb_pkg::RESP_OKAY);
      rd(c, x[23:16], gpb_pkg::RESP_OKAY);
      rd(e, {6'h0, x[25:24]}, gpb_pkg::RESP_OKAY);
   endtask
   task automatic pins_chk;
      repeat (2) @(negedge sys_clk_i);
      check({8'h0, pin_oe_o}, {8'h0, dir});
      check({8'h0, pin_o & dir}, {8'h0, dat & dir});
      check({8'h0, pin_pullup_o}, {8'h0, pu & ~dir});
      @(posedge sys_clk_i);
      rports(gpb_pkg::IDX_P0_DATA, gpb_pkg::IDX_P1_DATA,
         gpb_pkg::IDX_P2_DATA, gpb_pkg::IDX_P5_DATA,
         (dir & dat) | (~dir & (pu | ext)));
   endtask
   initial
   begin
      void'($urandom(98839));
      {dir, dat, pu} = '0;
      ext = 26'($urandom);
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      foreach (cfg_idx[k])
         rd(cfg_idx[k], gpb_pkg::RST_BYTE, gpb_pkg::RESP_OKAY);
      pins_chk();
      wr(8'h81, 8'h5A, gpb_pkg::RESP_SLVERR);
      rd(8'h81, 8'h00, gpb_pkg::RESP_SLVERR);
      for (int t = 0; t < 4; t++)
      begin
         @(posedge sys_clk_i);
         {dat, dir, pu, ext} <= {26'($urandom), 26'($urandom),
                                 26'($urandom), 26'($urandom)};
         @(posedge sys_clk_i);
         wports(gpb_pkg::IDX_P0_DATA, gpb_pkg::IDX_P1_DATA,
            gpb_pkg::IDX_P2_DATA, gpb_pkg::IDX_P5_DATA, dat);
         wports(gpb_pkg::IDX_P0_DIR, gpb_pkg::IDX_P1_DIR,
            gpb_pkg::IDX_P2_DIR, gpb_pkg::IDX_P5_DIR, dir);
         wports(gpb_pkg::IDX_P0_PULL, gpb_pkg::IDX_P1_PULL,
            gpb_pkg::IDX_P2_PULL, gpb_pkg::IDX_P5_PULL, pu);
         pins_chk();
         rports(gpb_pkg::IDX_P0_DIR, gpb_pkg::IDX_P1_DIR,
            gpb_pkg::IDX_P2_DIR, gpb_pkg::IDX_P5_DIR, dir);
      end
      for (int k = 0; k < 4; k++)
      begin
         v = {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)};
         wr(gpb_pkg::IDX_DRIVE, v, gpb_pkg::RESP_OKAY);
         repeat (2) @(negedge sys_clk_i);
         check({26'h0, drv}, {26'h0, v});
         @(posedge sys_clk_i);
         rd(gpb_pkg::IDX_DRIVE, v, gpb_pkg::RESP_OKAY);
      end
      wports(gpb_pkg::IDX_P0_DIR, gpb_pkg::IDX_P1_DIR,
         gpb_pkg::IDX_P2_DIR, gpb_pkg::IDX_P5_DIR, 26'h3FFFFFF);
      repeat (2) @(negedge sys_clk_i);
      check({8'h0, pin_oe_o}, {8'h0, 26'h3FFFFFF});
      @(posedge sys_clk_i);
      finish_test();
   end
endmodule
